// ===== hdl/i2cm_event_seq.sv
// What this block does
// - Acknowledge status: low ack clears, high sets.
// - Transmit write sets full; eighth bit clears.
// - Transmit write while shifting: discarded, collision.
// - Event bits ignore writes while event runs.
// - Receive enable clocks SCL, samples SDA bits.
// - Eighth receive fall: clear enable, load, interrupt.
// - Reading receive buffer clears its full flag.
// - Byte while full: set overflow, drop byte.
// - Overflow flag never blocks later reception.
// - Transmit write during other events: collision.
// - Ack request drives ACK or NACK bit.
// - Ack lasts two periods, then clears, interrupts.
// - Stop: SDA low, release SCL, release SDA.
// - Bus stop sets stop seen, clears start.
// - Restart: SCL low, release SDA, release SCL.
// - Restart: reload while SCL low, then SDA low.
// - Restart done: flags, clear request, interrupt.
// - Ninth fall captures ack, interrupts, idles.
// - Start request bit runs Start, self-clears.
`timescale 1ns/1ps
`default_nettype none

module i2cm_event_seq
(
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Register port.
  input  wire logic [i2cm_pkg::AW-1:0]    reg_addr,
  input  wire logic [i2cm_pkg::DW-1:0]    reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [i2cm_pkg::DW-1:0]    reg_rdata,
  // Bus clock pin, open drain.
  input  wire logic                       scl_i,
  output logic                            scl_o,
  output logic                            scl_oe_n,
  // Bus data pin, open drain.
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_n,
  // Event completion pulse.
  output logic                            master_event_irq
);

  // ---------------------------------------------------------------------
  // State of the whole block
  // ---------------------------------------------------------------------
  typedef struct packed {
    i2cm_pkg::i2cm_state_t state;
    logic [5:0]            control_reg;
    logic                  tx_buffer_full_flag;
    logic                  rx_buffer_full_flag;
    logic                  rx_overflow_flag;
    logic                  write_collision_flag;
    logic                  ack_status_flag;
    logic                  tx_active;
    logic                  start_seen;
    logic                  stop_seen;
    logic [7:0]            tx_shift;
    logic [7:0]            rx_shift_reg;
    logic [7:0]            rx_buffer_reg;
    logic [15:0]           bit_period;
    logic [15:0]           bit_period_counter;
    logic [3:0]            bit_num;
    logic                  scl_meta;
    logic                  scl_sync;
    logic                  sda_meta;
    logic                  sda_sync;
    logic                  sda_prev;
    logic                  scl_drive;
    logic                  sda_drive;
    logic                  irq;
    logic [15:0]           rdata;
  } i2cm_regs_t;

  localparam i2cm_regs_t RESET_V = '{
    state:      i2cm_pkg::SQ_IDLE,
    bit_period: i2cm_pkg::BIT_PER_RESET,
    scl_meta:   1'b1,
    scl_sync:   1'b1,
    sda_meta:   1'b1,
    sda_sync:   1'b1,
    sda_prev:   1'b1,
    default:    '0
  };

  i2cm_regs_t r_q;
  i2cm_regs_t r_d;
  logic       tick;
  logic       busy;
  logic [4:0] evt_req;
  logic [4:0] evt_one;
  logic [15:0] status_word;

  // ---------------------------------------------------------------------
  // Derived terms
  // ---------------------------------------------------------------------

  // Counter timeout marks the end of one bit period.
  assign tick = (r_q.bit_period_counter == 16'h0000);

  // Any event request or a running transmission makes the master busy.
  assign busy = (r_q.control_reg[4:0] != 5'h00) || r_q.tx_active;

  // Only the lowest requested event is taken, so one event runs at a time.
  assign evt_req = reg_wdata[4:0];
  assign evt_one = evt_req & (~evt_req + 5'h01);

  // Status word as software sees it.
  always_comb
  begin
    status_word                         = 16'h0000;
    status_word[i2cm_pkg::ST_TBF]       = r_q.tx_buffer_full_flag;
    status_word[i2cm_pkg::ST_RBF]       = r_q.rx_buffer_full_flag;
    status_word[i2cm_pkg::ST_START]     = r_q.start_seen;
    status_word[i2cm_pkg::ST_STOP]      = r_q.stop_seen;
    status_word[i2cm_pkg::ST_OV]        = r_q.rx_overflow_flag;
    status_word[i2cm_pkg::ST_WCOL]      = r_q.write_collision_flag;
    status_word[i2cm_pkg::ST_TRSTAT]    = r_q.tx_active;
    status_word[i2cm_pkg::ST_ACK_STATUS_FLAG]   = r_q.ack_status_flag;
  end

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------

  // Register access, pin sampling, bus watch and the event sequencer.
  always_comb
  begin
    r_d     = r_q;
    r_d.irq = 1'b0;

    // Two-stage synchronisers for the pins; only the second stage is used.
    r_d.scl_meta = scl_i;
    r_d.scl_sync = r_q.scl_meta;
    r_d.sda_meta = sda_i;
    r_d.sda_sync = r_q.sda_meta;
    r_d.sda_prev = r_q.sda_sync;

    // Free-running bit-period counter, reloaded at each timeout.
    r_d.bit_period_counter = tick ? r_q.bit_period : r_q.bit_period_counter - 16'h0001;

    // Start and stop conditions seen on the wires while SCL is high.
    if (r_q.scl_sync && r_q.sda_prev && !r_q.sda_sync)
    begin
      r_d.start_seen = 1'b1;
      r_d.stop_seen  = 1'b0;
    end
    if (r_q.scl_sync && !r_q.sda_prev && r_q.sda_sync)
    begin
      r_d.stop_seen  = 1'b1;
      r_d.start_seen = 1'b0;
    end

    // Read data stand for one cycle after the strobe, zero elsewhere.
    r_d.rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        i2cm_pkg::OFF_CONTROL: r_d.rdata = {10'h000, r_q.control_reg};
        i2cm_pkg::OFF_STATUS:  r_d.rdata = status_word;
        i2cm_pkg::OFF_TX_DATA: r_d.rdata = {8'h00, r_q.tx_shift};
        i2cm_pkg::OFF_RX_BUF:
        begin
          r_d.rdata               = {8'h00, r_q.rx_buffer_reg};
          r_d.rx_buffer_full_flag = 1'b0;
        end
        i2cm_pkg::OFF_BIT_PER: r_d.rdata = r_q.bit_period;
        default:               r_d.rdata = 16'h0000;
      endcase
    end

    // Software clears the sticky error flags by writing zero to them.
    if (reg_wr && (reg_addr == i2cm_pkg::OFF_STATUS))
    begin
      if (!reg_wdata[i2cm_pkg::ST_WCOL])
        r_d.write_collision_flag = 1'b0;
      if (!reg_wdata[i2cm_pkg::ST_OV])
        r_d.rx_overflow_flag = 1'b0;
    end
    if (reg_wr && (reg_addr == i2cm_pkg::OFF_BIT_PER))
      r_d.bit_period = reg_wdata;

    // Event sequencer.
    case (r_q.state)
      i2cm_pkg::SQ_IDLE:
      begin
      end
      // Start: SDA low under high SCL, then SCL low.
      i2cm_pkg::SQ_START_A:
      begin
        if (tick)
        begin
          r_d.scl_drive = 1'b1;
          r_d.state     = i2cm_pkg::SQ_START_B;
        end
      end
      i2cm_pkg::SQ_START_B:
      begin
        if (tick)
        begin
          r_d.control_reg[i2cm_pkg::CTL_START] = 1'b0;
          r_d.irq                              = 1'b1;
          r_d.state                            = i2cm_pkg::SQ_IDLE;
        end
      end
      // Low half of a bit: SCL held low for one period.
      i2cm_pkg::SQ_BIT_LO:
      begin
        if (tick)
        begin
          r_d.scl_drive = 1'b0;
          r_d.state     = i2cm_pkg::SQ_BIT_HI;
        end
      end
      // High half: the period counts only once SCL is really high.
      i2cm_pkg::SQ_BIT_HI:
      begin
        if (!r_q.scl_sync)
          r_d.bit_period_counter = r_q.bit_period;
        else if (tick)
        begin
          // Sample just before the falling edge, then pull SCL low.
          r_d.scl_drive = 1'b1;
          r_d.bit_num   = r_q.bit_num + 4'h1;
          r_d.state     = i2cm_pkg::SQ_BIT_LO;
          if (r_q.tx_active)
          begin
            if (r_q.bit_num == i2cm_pkg::ACK_BIT)
            begin
              r_d.ack_status_flag = r_q.sda_sync;
              r_d.tx_active       = 1'b0;
              r_d.irq             = 1'b1;
              r_d.state           = i2cm_pkg::SQ_IDLE;
            end
            else if (r_q.bit_num == i2cm_pkg::LAST_DATA_BIT)
            begin
              r_d.tx_buffer_full_flag = 1'b0;
              r_d.sda_drive           = 1'b0;
            end
            else
            begin
              r_d.sda_drive = ~r_q.tx_shift[7];
              r_d.tx_shift  = {r_q.tx_shift[6:0], 1'b0};
            end
          end
          else if (r_q.control_reg[i2cm_pkg::CTL_RX_EN])
          begin
            r_d.rx_shift_reg = {r_q.rx_shift_reg[6:0], r_q.sda_sync};
            if (r_q.bit_num == i2cm_pkg::LAST_DATA_BIT)
            begin
              r_d.control_reg[i2cm_pkg::CTL_RX_EN] = 1'b0;
              r_d.irq                              = 1'b1;
              r_d.state                            = i2cm_pkg::SQ_IDLE;
              if (r_q.rx_buffer_full_flag && !r_d.rx_buffer_full_flag)
              begin
                // Read in this very cycle frees the buffer for the new byte.
                r_d.rx_buffer_reg       = {r_q.rx_shift_reg[6:0], r_q.sda_sync};
                r_d.rx_buffer_full_flag = 1'b1;
              end
              else if (r_q.rx_buffer_full_flag)
                r_d.rx_overflow_flag = 1'b1;
              else
              begin
                r_d.rx_buffer_reg       = {r_q.rx_shift_reg[6:0], r_q.sda_sync};
                r_d.rx_buffer_full_flag = 1'b1;
              end
            end
          end
          else
          begin
            // Acknowledge bit done after its low and high period.
            r_d.control_reg[i2cm_pkg::CTL_ACK_EN] = 1'b0;
            r_d.irq                               = 1'b1;
            r_d.sda_drive                         = 1'b0;
            r_d.state                             = i2cm_pkg::SQ_IDLE;
          end
        end
      end
      // Stop: SDA low, release SCL, release SDA, one period each.
      i2cm_pkg::SQ_STOP_A:
      begin
        if (tick)
        begin
          r_d.scl_drive = 1'b0;
          r_d.state     = i2cm_pkg::SQ_STOP_B;
        end
      end
      i2cm_pkg::SQ_STOP_B:
      begin
        if (tick)
        begin
          r_d.sda_drive = 1'b0;
          r_d.state     = i2cm_pkg::SQ_STOP_C;
        end
      end
      i2cm_pkg::SQ_STOP_C:
      begin
        if (tick)
        begin
          r_d.control_reg[i2cm_pkg::CTL_STOP] = 1'b0;
          r_d.irq                             = 1'b1;
          r_d.state                           = i2cm_pkg::SQ_IDLE;
        end
      end
      // Restart: wait for SCL low, then release SDA for one period.
      i2cm_pkg::SQ_RS_A:
      begin
        r_d.bit_period_counter = r_q.bit_period;
        if (!r_q.scl_sync)
        begin
          r_d.sda_drive = 1'b0;
          r_d.state     = i2cm_pkg::SQ_RS_B;
        end
      end
      i2cm_pkg::SQ_RS_B:
      begin
        if (tick && r_q.sda_sync)
        begin
          r_d.scl_drive = 1'b0;
          r_d.state     = i2cm_pkg::SQ_RS_C;
        end
      end
      // Both lines high for one period, counted from SCL seen high.
      i2cm_pkg::SQ_RS_C:
      begin
        if (!r_q.scl_sync)
          r_d.bit_period_counter = r_q.bit_period;
        else if (tick)
        begin
          r_d.sda_drive = 1'b1;
          r_d.state     = i2cm_pkg::SQ_RS_D;
        end
      end
      // SDA low under high SCL for one period, then leave SCL low.
      i2cm_pkg::SQ_RS_D:
      begin
        if (tick)
        begin
          r_d.scl_drive                          = 1'b1;
          r_d.start_seen                         = 1'b1;
          r_d.stop_seen                          = 1'b0;
          r_d.control_reg[i2cm_pkg::CTL_RESTART] = 1'b0;
          r_d.irq                                = 1'b1;
          r_d.state                              = i2cm_pkg::SQ_IDLE;
        end
      end
      default:
      begin
        r_d.state = i2cm_pkg::SQ_IDLE;
      end
    endcase

    // Transmit write: taken only when the master is idle.
    if (reg_wr && (reg_addr == i2cm_pkg::OFF_TX_DATA))
    begin
      if (busy)
        r_d.write_collision_flag = 1'b1;
      else
      begin
        r_d.tx_buffer_full_flag = 1'b1;
        r_d.tx_active           = 1'b1;
        r_d.sda_drive           = ~reg_wdata[7];
        r_d.tx_shift            = {reg_wdata[6:0], 1'b0};
        r_d.bit_num             = 4'h0;
        r_d.bit_period_counter  = r_q.bit_period;
        r_d.state               = i2cm_pkg::SQ_BIT_LO;
      end
    end

    // Control write: ack data always, event bits only when idle.
    if (reg_wr && (reg_addr == i2cm_pkg::OFF_CONTROL))
    begin
      r_d.control_reg[i2cm_pkg::CTL_ACK_DT] = reg_wdata[i2cm_pkg::CTL_ACK_DT];
      if (!busy)
      begin
        r_d.control_reg[4:0]   = evt_one;
        r_d.bit_period_counter = r_q.bit_period;
        r_d.bit_num            = 4'h0;
        if (evt_one[i2cm_pkg::CTL_START])
        begin
          r_d.sda_drive = 1'b1;
          r_d.state     = i2cm_pkg::SQ_START_A;
        end
        else if (evt_one[i2cm_pkg::CTL_RESTART])
        begin
          r_d.scl_drive = 1'b1;
          r_d.state     = i2cm_pkg::SQ_RS_A;
        end
        else if (evt_one[i2cm_pkg::CTL_STOP])
        begin
          r_d.sda_drive = 1'b1;
          r_d.state     = i2cm_pkg::SQ_STOP_A;
        end
        else if (evt_one[i2cm_pkg::CTL_RX_EN])
        begin
          r_d.sda_drive = 1'b0;
          r_d.state     = i2cm_pkg::SQ_BIT_LO;
        end
        else if (evt_one[i2cm_pkg::CTL_ACK_EN])
        begin
          r_d.sda_drive = ~reg_wdata[i2cm_pkg::CTL_ACK_DT];
          r_d.state     = i2cm_pkg::SQ_BIT_LO;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------

  // All state is held in one register with an asynchronous reset.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      r_q <= RESET_V;
    else
      r_q <= r_d;
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------

  // Open-drain pins only ever pull low; enable is low while pulling.
  assign scl_o            = 1'b0;
  assign sda_o            = 1'b0;
  assign scl_oe_n         = ~r_q.scl_drive;
  assign sda_oe_n         = ~r_q.sda_drive;
  assign master_event_irq = r_q.irq;
  assign reg_rdata        = r_q.rdata;

endmodule

`default_nettype wire

// ===== hdl/i2cm_pkg.sv
package i2cm_pkg;

  // ---------------------------------------------------------------------
  // Register bus geometry and register byte addresses
  // ---------------------------------------------------------------------
  localparam int unsigned AW          = 8;
  localparam int unsigned DW          = 16;
  localparam logic [7:0]  OFF_CONTROL = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_TX_DATA = 8'h08;
  localparam logic [7:0]  OFF_RX_BUF  = 8'h0c;
  localparam logic [7:0]  OFF_BIT_PER = 8'h10;

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------
  localparam int unsigned CTL_START   = 0;
  localparam int unsigned CTL_RESTART = 1;
  localparam int unsigned CTL_STOP    = 2;
  localparam int unsigned CTL_RX_EN   = 3;
  localparam int unsigned CTL_ACK_EN  = 4;
  localparam int unsigned CTL_ACK_DT  = 5;
  localparam int unsigned CTL_EVT_W   = 5;

  // ---------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------
  localparam int unsigned ST_TBF      = 0;
  localparam int unsigned ST_RBF      = 1;
  localparam int unsigned ST_START    = 3;
  localparam int unsigned ST_STOP     = 4;
  localparam int unsigned ST_OV       = 6;
  localparam int unsigned ST_WCOL     = 7;
  localparam int unsigned ST_TRSTAT   = 14;
  localparam int unsigned ST_ACK_STATUS_FLAG  = 15;

  // ---------------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------------
  localparam logic [15:0] BIT_PER_RESET = 16'h0009;
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
  localparam logic [3:0]  ACK_BIT       = 4'h8;

  // ---------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    SQ_IDLE,
    SQ_START_A,
    SQ_START_B,
    SQ_BIT_LO,
    SQ_BIT_HI,
    SQ_STOP_A,
    SQ_STOP_B,
    SQ_STOP_C,
    SQ_RS_A,
    SQ_RS_B,
    SQ_RS_C,
    SQ_RS_D
  } i2cm_state_t;

endpackage

// ===== tb/i2cm_event_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module i2cm_event_seq_sva
(
  // Clock and reset.
  input wire logic                    clk,
  input wire logic                    resetn,
  // Register port.
  input wire logic [i2cm_pkg::AW-1:0] reg_addr,
  input wire logic [i2cm_pkg::DW-1:0] reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [i2cm_pkg::DW-1:0] reg_rdata,
  // Bus pins and event pulse.
  input wire logic                    scl_i,
  input wire logic                    scl_o,
  input wire logic                    scl_oe_n,
  input wire logic                    sda_i,
  input wire logic                    sda_o,
  input wire logic                    sda_oe_n,
  input wire logic                    master_event_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Register accesses that the properties are built from.
  sequence s_wr_tx;
    reg_wr && reg_addr == i2cm_pkg::OFF_TX_DATA;
  endsequence
  sequence s_rd_st;
    reg_rd && reg_addr == i2cm_pkg::OFF_STATUS;
  endsequence
  sequence s_rd_rx;
    reg_rd && reg_addr == i2cm_pkg::OFF_RX_BUF;
  endsequence

  // Status, pulse and pin relations.
  AST_TBF_SET: assert property (s_wr_tx ##1 s_rd_st |=> reg_rdata[i2cm_pkg::ST_TBF])
    else $error("transmit write left the full flag clear");
  AST_WCOL: assert property (s_wr_tx ##1 s_wr_tx ##1 s_rd_st |=> reg_rdata[7])
    else $error("second transmit write left collision clear");
  AST_RBF_CLR: assert property (s_rd_rx ##1 s_rd_st |=> !reg_rdata[1])
    else $error("receive read left the full flag set");
  AST_IRQ_PULSE: assert property (master_event_irq |=> !master_event_irq)
    else $error("event pulse longer than one cycle");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_PINS_LOW: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain data not low");
  AST_REL_RESET: assert property ($rose(resetn) |-> scl_oe_n && sda_oe_n)
    else $error("pins not released after reset");
  AST_STOP_SEQ: assert property ($rose(sda_oe_n) && scl_oe_n |-> $past(scl_oe_n, 8) && !$past(sda_oe_n, 8))
    else $error("data released too soon after clock release");
  AST_RS_HIGH: assert property ($fell(sda_oe_n) && scl_oe_n |-> $past(scl_oe_n, 8) && $past(sda_oe_n, 8))
    else $error("start edge without a full high period");
endmodule
`default_nettype wire

// ===== tb/i2cm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Slave on the two-wire bus
// ------------------------------------------------------------
module i2cm_slave_model
(
  // Bus wires.
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour controls.
  input  wire logic       rx_mode,
  input  wire logic [7:0] rx_byte,
  input  wire logic       ack_n,
  // Slave outputs.
  output logic            sda_pull,
  output logic [7:0]      got_byte
);
  logic [3:0] cnt = 4'he;

  // Start restarts the bit count, stop parks it at the idle code.
  // A short wait keeps a data change at a falling clock from posing as a condition.
  always @(negedge sda) #1 if (scl) cnt = 4'hf;
  always @(posedge sda) #1 if (scl) cnt = 4'he;
  // Each falling clock steps to the next slot; slot 8 is acknowledge.
  always @(negedge scl) if (cnt != 4'he) cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
  // Data bits are taken while the clock is high.
  always @(posedge scl) if (cnt < 4'h8) got_byte = {got_byte[6:0], sda};
  // Drive data in receive mode, else the acknowledge slot only.
  assign sda_pull = rx_mode ? (cnt < 4'h8 && !rx_byte[3'h7 - cnt[2:0]])
                            : (cnt == 4'h8 && !ack_n);
endmodule
`default_nettype wire

// ===== tb/tb_i2cm_event_seq.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module tb_i2cm_event_seq;
  localparam logic [15:0] RELOAD = 16'h0013;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata, rv, sv;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, irq, sda_pull, saw_low;
  logic        rx_mode = 1'b0;
  logic        ack_n = 1'b0;
  logic [7:0]  rx_byte = 8'h00;
  logic [7:0]  got_byte;
  logic [7:0]  b [4];
  int          mismatches = 0;
  int          check_count = 0;
  int          n;
  wire         scl_w = scl_oe_n;
  wire         sda_w = sda_oe_n & ~sda_pull;

  i2cm_event_seq i_i2cm_event_seq (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .master_event_irq(irq));
  i2cm_slave_model i_i2cm_slave_model (.scl(scl_w), .sda(sda_w), .rx_mode(rx_mode),
    .rx_byte(rx_byte), .ack_n(ack_n), .sda_pull(sda_pull), .got_byte(got_byte));

  // Clock of 4 ns.
  always #2 clk = ~clk;

  // One bus cycle; rv takes the data that stood in the cycle just ended.
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    rv = reg_rdata;
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, a, d);
    acc(1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    acc(1'b0, 1'b1, a, 16'h0000);
    acc(1'b0, 1'b0, a, 16'h0000);
    acc(1'b0, 1'b0, a, 16'h0000);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      $display("BAD %0t %s", $time, m);
      mismatches++;
    end
  endtask
  // Bounded wait for the event pulse, noting whether SDA was pulled.
  task automatic wait_irq;
    n = 0;
    saw_low = 1'b0;
    do
    begin
      @(posedge clk);
      n++;
      if (sda_oe_n === 1'b0) saw_low = 1'b1;
    end while (irq !== 1'b1 && n < 3000);
    chk(16'(n < 3000), 16'h0001, "no event pulse");
  endtask
  function automatic logic [15:0] bit_of(input logic [15:0] v, input int i);
    return {15'h0000, v[i]};
  endfunction
  function automatic int ack_len_ok(input int cyc);
    return int'(cyc >= 2 * (RELOAD + 1) - 2 && cyc <= 2 * (RELOAD + 1) + 10);
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well beyond the expected run.
  initial
  begin
    #200000;
    mismatches++;
    wrap_up();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(62276));
    foreach (b[i]) b[i] = 8'($urandom);
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h20);
    chk(rv, 16'h0000, "unmapped read");
    wr(i2cm_pkg::OFF_BIT_PER, RELOAD);
    rd(i2cm_pkg::OFF_BIT_PER);
    chk(rv, RELOAD, "bit period readback");
    wr(i2cm_pkg::OFF_CONTROL, 16'h0001);
    wait_irq();
    rd(i2cm_pkg::OFF_CONTROL);
    chk(rv & 16'h001f, 16'h0000, "start bit stuck");
    rd(i2cm_pkg::OFF_STATUS);
    chk(bit_of(rv, i2cm_pkg::ST_START), 16'h0001, "start not seen");
    $display("test start done");
    for (int i = 0; i < 2; i++)
    begin
      ack_n = i[0];
      acc(1'b1, 1'b0, i2cm_pkg::OFF_TX_DATA, {8'h00, b[i]});
      acc(1'b1, 1'b0, i2cm_pkg::OFF_TX_DATA, {8'h00, ~b[i]});
      acc(1'b0, 1'b1, i2cm_pkg::OFF_STATUS, 16'h0000);
      acc(1'b1, 1'b0, i2cm_pkg::OFF_CONTROL, 16'h0004);
      acc(1'b0, 1'b0, i2cm_pkg::OFF_STATUS, 16'h0000);
      sv = rv;
      rd(i2cm_pkg::OFF_CONTROL);
      chk(bit_of(sv, i2cm_pkg::ST_TBF), 16'h0001, "full flag clear");
      chk(bit_of(sv, i2cm_pkg::ST_WCOL), 16'h0001, "no collision");
      chk(rv & 16'h001f, 16'h0000, "control taken while busy");
      wait_irq();
      chk({8'h00, got_byte}, {8'h00, b[i]}, "byte on wire");
      rd(i2cm_pkg::OFF_STATUS);
      chk(bit_of(rv, i2cm_pkg::ST_TBF), 16'h0000, "full flag stuck");
      chk(bit_of(rv, i2cm_pkg::ST_ACK_STATUS_FLAG), {15'h0000, ack_n}, "ack status");
      chk(bit_of(rv, i2cm_pkg::ST_TRSTAT), 16'h0000, "still transmitting");
      wr(i2cm_pkg::OFF_STATUS, 16'h0000);
      rd(i2cm_pkg::OFF_STATUS);
      chk(bit_of(rv, i2cm_pkg::ST_WCOL), 16'h0000, "collision not cleared");
    end
    $display("test transmit done");
    wr(i2cm_pkg::OFF_CONTROL, 16'h0002);
    wait_irq();
    rd(i2cm_pkg::OFF_STATUS);
    chk(rv & 16'h0018, 16'h0008, "restart flags");
    ack_n = 1'b0;
    wr(i2cm_pkg::OFF_TX_DATA, {8'h00, b[2] | 8'h01});
    wait_irq();
    rd(i2cm_pkg::OFF_CONTROL);
    chk(rv & 16'h001f, 16'h0000, "restart bit stuck");
    $display("test restart done");
    rx_mode = 1'b1;
    rx_byte = b[0];
    wr(i2cm_pkg::OFF_CONTROL, 16'h0008);
    wr(i2cm_pkg::OFF_TX_DATA, 16'h005a);
    wait_irq();
    rx_byte = b[1];
    rd(i2cm_pkg::OFF_CONTROL);
    chk(bit_of(rv, i2cm_pkg::CTL_RX_EN), 16'h0000, "receive enable stuck");
    rd(i2cm_pkg::OFF_STATUS);
    chk(rv & 16'h0082, 16'h0082, "full or collision missing");
    wr(i2cm_pkg::OFF_CONTROL, 16'h0010);
    wait_irq();
    chk(16'(ack_len_ok(n)), 16'h0001, "ack length");
    chk({15'h0000, saw_low}, 16'h0001, "ack not driven low");
    wr(i2cm_pkg::OFF_CONTROL, 16'h0008);
    wait_irq();
    rx_byte = b[2];
    rd(i2cm_pkg::OFF_STATUS);
    chk(bit_of(rv, i2cm_pkg::ST_OV), 16'h0001, "overflow missing");
    acc(1'b0, 1'b1, i2cm_pkg::OFF_RX_BUF, 16'h0000);
    acc(1'b0, 1'b1, i2cm_pkg::OFF_STATUS, 16'h0000);
    acc(1'b0, 1'b0, i2cm_pkg::OFF_STATUS, 16'h0000);
    chk(rv, {8'h00, b[0]}, "old byte lost");
    acc(1'b0, 1'b0, i2cm_pkg::OFF_STATUS, 16'h0000);
    chk(bit_of(rv, i2cm_pkg::ST_RBF), 16'h0000, "full flag after read");
    wr(i2cm_pkg::OFF_CONTROL, 16'h0030);
    wait_irq();
    chk({15'h0000, saw_low}, 16'h0000, "nack pulled data");
    wr(i2cm_pkg::OFF_CONTROL, 16'h0008);
    wait_irq();
    rd(i2cm_pkg::OFF_RX_BUF);
    chk(rv, {8'h00, b[2]}, "byte after overflow");
    $display("test receive done");
    wr(i2cm_pkg::OFF_CONTROL, 16'h0004);
    wait_irq();
    rd(i2cm_pkg::OFF_STATUS);
    chk(rv & 16'h0018, 16'h0010, "stop flags");
    chk({14'h0000, scl_w, sda_w}, 16'h0003, "bus not released");
    $display("test stop done");
    wrap_up();
  end
endmodule

bind i2cm_event_seq i2cm_event_seq_sva i_i2cm_event_seq_sva (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .master_event_irq(master_event_irq));
`default_nettype wire
